// >>> pkg/fpl_consts.svh
`ifndef FPL_CONSTS_SVH
`define FPL_CONSTS_SVH
`define FPL_CLK_MHZ 125
`define FPL_QUAL_US 10
`define FPL_QUAL_CYC (`FPL_QUAL_US * `FPL_CLK_MHZ)
`define FPL_EXT65_US 55
`define FPL_EXT65_CYC (`FPL_EXT65_US * `FPL_CLK_MHZ)
`define FPL_EXT100_US 35
`define FPL_EXT100_CYC (`FPL_EXT100_US * `FPL_CLK_MHZ)
`define FPL_LHI_US 50
`define FPL_LHI_CYC (`FPL_LHI_US * `FPL_CLK_MHZ)
`define FPL_LLO_US 350
`define FPL_LLO_CYC (`FPL_LLO_US * `FPL_CLK_MHZ)
`define FPL_OFF_MS 600
`define FPL_OFF_CYC (`FPL_OFF_MS * 1000 * `FPL_CLK_MHZ)
`define FPL_FAULT_US 128
`define FPL_FAULT_CYC (`FPL_FAULT_US * `FPL_CLK_MHZ)
`define FPL_SS_US 4000
`define FPL_SS_CYC (`FPL_SS_US * `FPL_CLK_MHZ)
`define FPL_AUTOREC_MS 1000
`define FPL_AUTOREC_CYC (`FPL_AUTOREC_MS * 1000 * `FPL_CLK_MHZ)
`define FPL_ADDR_W 4
`define FPL_CTRL_OFS 4'h0
`define FPL_STATUS_OFS 4'h4
`define FPL_CTRL_OPTB 0
`define FPL_CTRL_V100 1
`define FPL_CTRL_RST 2'h0
`define FPL_RESP_OKAY 2'h0
`define FPL_RESP_SLVERR 2'h2
`define FPL_C_OC 0
`define FPL_C_SHORT 1
`define FPL_C_UV 2
`define FPL_C_EXT 3
`define FPL_C_OVP 4
`define FPL_C_LPIN 5
`define FPL_NCAUSE 6
`endif

// >>> pkg/fpl_pkg.sv
package fpl_pkg;
  typedef enum logic [2:0] {
    FPL_WAIT, FPL_SOFTSTART, FPL_RUN, FPL_LATCHED,
    FPL_AUTOREC, FPL_THERMAL, FPL_OFFMODE
  } fpl_state_type;
endpackage : fpl_pkg

// >>> pkg/fpl_reg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fpl_reg_if;
  logic opt_autorec;
  logic var_100k;
  logic [31:0] status;
  modport regs (output opt_autorec, output var_100k, input status);
  modport core (input opt_autorec, input var_100k, output status);
endinterface : fpl_reg_if
`default_nettype wire

// >>> design/fpl_qual_timer.sv
`timescale 1ns/10ps
`default_nettype none
module fpl_qual_timer #(
  parameter int W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic arm,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] count;

  generate
    if (W < 1) begin : g_bad
      $error("fpl_qual_timer: width must be at least 1");
    end
  endgenerate

  // counts while armed, holds at limit, clears when disarmed
  always_ff @(posedge aclk) begin
    if (!aresetn || !arm) begin
      count <= '0;
    end else if (count != limit) begin
      count <= count + 1'b1;
    end
  end

  assign done = arm && (count == limit);
endmodule : fpl_qual_timer
`default_nettype wire

// >>> design/fpl_axil_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpl_consts.svh"
module fpl_axil_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`FPL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`FPL_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  fpl_reg_if.regs rif
);
  logic aw_held;
  logic w_held;
  logic [`FPL_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic commit;

  assign commit = aw_held && w_held && !s_axi_bvalid;

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FPL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (commit) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == `FPL_CTRL_OFS ||
                        aw_addr == `FPL_STATUS_OFS) ?
                       `FPL_RESP_OKAY : `FPL_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {rif.var_100k, rif.opt_autorec} <= `FPL_CTRL_RST;
    end else if (commit && aw_addr == `FPL_CTRL_OFS && w_lane0) begin
      rif.opt_autorec <= w_data[`FPL_CTRL_OPTB];
      rif.var_100k <= w_data[`FPL_CTRL_V100];
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `FPL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FPL_RESP_OKAY;
      s_axi_rdata <= '0;
      if (s_axi_araddr == `FPL_CTRL_OFS) begin
        s_axi_rdata[`FPL_CTRL_OPTB] <= rif.opt_autorec;
        s_axi_rdata[`FPL_CTRL_V100] <= rif.var_100k;
      end else if (s_axi_araddr == `FPL_STATUS_OFS) begin
        s_axi_rdata <= rif.status;
      end else begin
        s_axi_rresp <= `FPL_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : fpl_axil_regs
`default_nettype wire

// >>> design/fpl_protection_seq.sv
`timescale 1ns/10ps
`default_nettype none
`include "fpl_consts.svh"
module fpl_protection_seq
  import fpl_pkg::*;
#(
  parameter int unsigned FAULT_CYC = `FPL_FAULT_CYC,
  parameter int unsigned QUAL_CYC = `FPL_QUAL_CYC,
  parameter int unsigned EXT65_CYC = `FPL_EXT65_CYC,
  parameter int unsigned EXT100_CYC = `FPL_EXT100_CYC,
  parameter int unsigned LHI_CYC = `FPL_LHI_CYC,
  parameter int unsigned LLO_CYC = `FPL_LLO_CYC,
  parameter int unsigned OFF_CYC = `FPL_OFF_CYC,
  parameter int unsigned SS_CYC = `FPL_SS_CYC,
  parameter int unsigned AUTOREC_CYC = `FPL_AUTOREC_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`FPL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`FPL_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic current_limit_level,
  input wire logic cs_stop_level,
  input wire logic vcc_below_off,
  input wire logic vcc_below_reset,
  input wire logic vcc_above_on,
  input wire logic vcc_above_ovp,
  input wire logic ext_latch_req,
  input wire logic latch_pin_high,
  input wire logic latch_pin_low,
  input wire logic thermal_shutdown_flag,
  input wire logic thermal_fault_cleared,
  input wire logic offmode_feedback_threshold,
  input wire logic onmode_feedback_threshold,
  input wire logic x2_discharge_done,
  output logic gate_drive_output,
  output logic softstart_bias_boost,
  output logic hv_startup_enable,
  output logic internal_supply_enable
);
  localparam int NT = 8;
  localparam int T_FAULT = 0;
  localparam int T_UV = 1;
  localparam int T_EXT = 2;
  localparam int T_OVP = 3;
  localparam int T_TSD = 4;
  localparam int T_OFF = 5;
  localparam int T_LHI = 6;
  localparam int T_LLO = 7;

  generate
    if (FAULT_CYC == 0 || QUAL_CYC == 0 || EXT65_CYC == 0 ||
        EXT100_CYC == 0 || LHI_CYC == 0 || LLO_CYC == 0 ||
        OFF_CYC == 0 || SS_CYC == 0 || AUTOREC_CYC == 0) begin : g_bad
      $error("fpl_protection_seq: every count must be at least 1");
    end
  endgenerate

  fpl_reg_if rif ();

  fpl_axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(rif.regs)
  );

  fpl_state_type state;
  fpl_state_type next_state;
  logic [`FPL_NCAUSE-1:0] cause;
  logic [`FPL_NCAUSE-1:0] next_cause;
  logic [`FPL_NCAUSE-1:0] trip;
  logic [`FPL_NCAUSE-1:0] rel_ok;
  logic [31:0] phase_cnt;
  logic running;
  logic [NT-1:0] tm_arm;
  logic [NT-1:0] tm_done;
  logic [31:0] tm_lim [NT];

  assign running = (state == FPL_SOFTSTART) || (state == FPL_RUN);

  // qualification arming; only the thermal timer is also armed outside the live states, in wait
  always_comb begin
    tm_arm = '0;
    tm_arm[T_FAULT] = running && current_limit_level;
    tm_arm[T_UV] = running && vcc_below_off;
    tm_arm[T_EXT] = running && ext_latch_req;
    tm_arm[T_OVP] = running && vcc_above_ovp;
    tm_arm[T_TSD] = (running || state == FPL_WAIT) &&
                    thermal_shutdown_flag;
    tm_arm[T_OFF] = (state == FPL_RUN) &&
                    offmode_feedback_threshold;
    tm_arm[T_LHI] = running && latch_pin_high;
    tm_arm[T_LLO] = (state == FPL_RUN) && latch_pin_low;
  end

  always_comb begin
    tm_lim[T_FAULT] = FAULT_CYC;
    tm_lim[T_UV] = QUAL_CYC;
    tm_lim[T_EXT] = rif.var_100k ? EXT100_CYC : EXT65_CYC;
    tm_lim[T_OVP] = QUAL_CYC;
    tm_lim[T_TSD] = QUAL_CYC;
    tm_lim[T_OFF] = OFF_CYC;
    tm_lim[T_LHI] = LHI_CYC;
    tm_lim[T_LLO] = LLO_CYC;
  end

  generate
    for (genvar gi = 0; gi < NT; gi++) begin : g_tmr
      fpl_qual_timer #(.W(32)) u_tmr (
        .aclk(aclk),
        .aresetn(aresetn),
        .arm(tm_arm[gi]),
        .limit(tm_lim[gi]),
        .done(tm_done[gi])
      );
    end
  endgenerate

  // latch causes from qualified events, the winding short from its level at once
  always_comb begin
    trip = '0;
    trip[`FPL_C_OC] = tm_done[T_FAULT];
    trip[`FPL_C_SHORT] = running && cs_stop_level;
    trip[`FPL_C_UV] = tm_done[T_UV];
    trip[`FPL_C_EXT] = tm_done[T_EXT];
    trip[`FPL_C_OVP] = tm_done[T_OVP];
    trip[`FPL_C_LPIN] = tm_done[T_LHI] || tm_done[T_LLO];
  end

  // per-cause release conditions
  always_comb begin
    rel_ok = '1;
    rel_ok[`FPL_C_OC] = !cause[`FPL_C_OC] ||
                        x2_discharge_done || vcc_below_reset;
    rel_ok[`FPL_C_SHORT] = !cause[`FPL_C_SHORT] ||
                           x2_discharge_done || vcc_below_reset;
    rel_ok[`FPL_C_UV] = !cause[`FPL_C_UV] ||
                        x2_discharge_done || !vcc_below_reset;
    rel_ok[`FPL_C_EXT] = !cause[`FPL_C_EXT] ||
                         x2_discharge_done || !vcc_above_on;
    rel_ok[`FPL_C_OVP] = !cause[`FPL_C_OVP] ||
                         x2_discharge_done || vcc_below_reset;
    rel_ok[`FPL_C_LPIN] = !cause[`FPL_C_LPIN] || vcc_below_reset;
  end

  always_comb begin
    next_state = state;
    next_cause = cause;
    unique case (state)
      FPL_WAIT: begin
        if (tm_done[T_TSD]) begin
          next_state = FPL_THERMAL;
        end else if (vcc_above_on) begin
          if (latch_pin_high) begin
            next_state = FPL_LATCHED;
            next_cause[`FPL_C_LPIN] = 1'b1;
          end else begin
            next_state = FPL_SOFTSTART;
          end
        end
      end
      FPL_SOFTSTART, FPL_RUN: begin
        if (tm_done[T_TSD]) begin
          next_state = FPL_THERMAL;
        end else if (|trip) begin
          next_state = FPL_LATCHED;
          next_cause = trip;
        end else if (tm_done[T_OFF]) begin
          next_state = FPL_OFFMODE;
        end else if (state == FPL_SOFTSTART &&
                     phase_cnt == SS_CYC - 1) begin
          next_state = FPL_RUN;
        end
      end
      FPL_LATCHED: begin
        if (&rel_ok) begin
          next_state = FPL_WAIT;
          next_cause = '0;
        end else if (rif.opt_autorec &&
                     !(|cause[`FPL_NCAUSE-1:`FPL_C_UV])) begin
          next_state = FPL_AUTOREC;
        end
      end
      FPL_AUTOREC: begin
        if (x2_discharge_done || vcc_below_reset ||
            phase_cnt == AUTOREC_CYC - 1) begin
          next_state = FPL_WAIT;
          next_cause = '0;
        end
      end
      FPL_THERMAL: begin
        if (vcc_above_on && thermal_fault_cleared) begin
          next_state = FPL_SOFTSTART;
        end
      end
      FPL_OFFMODE: begin
        if (vcc_above_on && onmode_feedback_threshold) begin
          next_state = FPL_SOFTSTART;
        end
      end
      default: begin
        next_state = FPL_WAIT;
        next_cause = '0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= FPL_WAIT;
      cause <= '0;
    end else begin
      state <= next_state;
      cause <= next_cause;
    end
  end

  // soft-start and recovery delay counter
  always_ff @(posedge aclk) begin
    if (!aresetn || next_state != state) begin
      phase_cnt <= '0;
    end else if (phase_cnt != 32'hFFFFFFFF) begin
      phase_cnt <= phase_cnt + 32'h00000001;
    end
  end

  // registered pin controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_drive_output <= 1'b0;
      softstart_bias_boost <= 1'b0;
      hv_startup_enable <= 1'b1;
      internal_supply_enable <= 1'b1;
    end else begin
      gate_drive_output <= (next_state == FPL_SOFTSTART ||
                            next_state == FPL_RUN) &&
                           !thermal_shutdown_flag;
      softstart_bias_boost <= next_state == FPL_SOFTSTART;
      hv_startup_enable <= next_state != FPL_THERMAL;
      internal_supply_enable <= next_state != FPL_OFFMODE;
    end
  end

  assign rif.status = {16'h0000, gate_drive_output,
                       softstart_bias_boost, hv_startup_enable,
                       internal_supply_enable, 2'h0, cause,
                       1'b0, state};

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_oc_latch: assert property (running && tm_done[T_FAULT] &&
      !tm_done[T_TSD] |=> state == FPL_LATCHED && cause[`FPL_C_OC])
    else $error("fault timer expiry did not latch");
  a_short_now: assert property (running && cs_stop_level &&
      !tm_done[T_TSD] |=> state == FPL_LATCHED && !gate_drive_output)
    else $error("winding short did not latch at once");
  a_uv_qual: assert property (running && vcc_below_off &&
      !tm_done[T_UV] |=> !cause[`FPL_C_UV])
    else $error("low supply latched before its timer");
  a_fault_clear: assert property (!current_limit_level |=>
      !tm_done[T_FAULT])
    else $error("fault timer survived current drop");
  a_llo_blank: assert property (state == FPL_SOFTSTART |->
      !tm_arm[T_LLO])
    else $error("low latch seen during soft-start");
  a_boost_ss: assert property (state == FPL_SOFTSTART ##1
      state == FPL_RUN |-> !softstart_bias_boost &&
      $past(softstart_bias_boost))
    else $error("bias boost not tied to soft-start");
  a_hi_turnon: assert property (state == FPL_WAIT && vcc_above_on &&
      latch_pin_high && !tm_done[T_TSD] |=>
      state == FPL_LATCHED ##1 !gate_drive_output)
    else $error("high latch at turn-on did not block start");
  a_tsd_gate: assert property (running && thermal_shutdown_flag |=>
      !gate_drive_output)
    else $error("gate still driven on thermal flag");
  a_tsd_supply: assert property (state == FPL_THERMAL |->
      !hv_startup_enable && internal_supply_enable)
    else $error("thermal stop supply controls wrong");
  a_off_supply: assert property (state == FPL_OFFMODE |->
      !internal_supply_enable && !gate_drive_output)
    else $error("off mode left supply or gate on");
  a_lpin_hold: assert property (state == FPL_LATCHED &&
      cause[`FPL_C_LPIN] && !vcc_below_reset |=>
      state == FPL_LATCHED)
    else $error("latch input state released early");
  a_latch_quiet: assert property (state == FPL_LATCHED |->
      !gate_drive_output && tm_done == '0)
    else $error("gate or timer active while latched");
  a_reset_wait: assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> state == FPL_WAIT && cause == '0)
    else $error("reset did not clear sequencer");

  c_run: cover property (state == FPL_SOFTSTART ##1 state == FPL_RUN);
  c_oc: cover property (state == FPL_LATCHED && cause[`FPL_C_OC]);
  c_autorec: cover property (state == FPL_AUTOREC ##1 state == FPL_WAIT);
  c_thermal: cover property (state == FPL_THERMAL ##1
      state == FPL_SOFTSTART);
endmodule : fpl_protection_seq
`default_nettype wire

// >>> dv/fpl_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
module fpl_analog_model (
  input wire logic [2:0] vcc_code,
  input wire logic hot,
  output logic vcc_below_reset,
  output logic vcc_below_off,
  output logic vcc_above_on,
  output logic vcc_above_ovp,
  output logic thermal_shutdown_flag,
  output logic thermal_fault_cleared
);
  // supply code: 0 reset, 1 below off, 2 mid, 3 above on, 4 ovp
  assign vcc_below_reset = (vcc_code == 3'h0);
  assign vcc_below_off = (vcc_code <= 3'h1);
  assign vcc_above_on = (vcc_code >= 3'h3);
  assign vcc_above_ovp = (vcc_code == 3'h4);
  // sensor comparator, hysteresis held by the bench
  assign thermal_shutdown_flag = hot;
  assign thermal_fault_cleared = !hot;
endmodule : fpl_analog_model
`default_nettype wire

// >>> dv/flyback_protection_latch_sequencer_test.sv
`timescale 1ns/10ps
`default_nettype none
module flyback_protection_latch_sequencer_test;
  localparam int FC = 8, QC = 4, E65 = 20, E100 = 6, LH = 5, LL = 7;
  localparam int OFF = 10, SS = 12, AR = 20;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, gate_drive_output, softstart_bias_boost;
  logic hv_startup_enable, internal_supply_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [8:0] flt = 9'h100;
  logic [2:0] vcc_code = 3'h2;
  logic vcc_below_off, vcc_below_reset, vcc_above_on, vcc_above_ovp;
  logic thermal_shutdown_flag, thermal_fault_cleared;
  int fails = 0, compares = 0;
  // fault inputs: 0 oc, 1 short, 2 ext, 3 pin high, 4 pin low, 5 fb off
  wire current_limit_level = flt[0];
  wire cs_stop_level = flt[1];
  wire ext_latch_req = flt[2];
  wire latch_pin_high = flt[3];
  wire latch_pin_low = flt[4];
  wire offmode_feedback_threshold = flt[5];
  wire x2_discharge_done = flt[6];
  wire onmode_feedback_threshold = flt[8];
  fpl_analog_model model_u (.vcc_code, .hot(flt[7]), .vcc_below_reset,
    .vcc_below_off, .vcc_above_on, .vcc_above_ovp, .thermal_shutdown_flag,
    .thermal_fault_cleared);
  fpl_protection_seq #(.FAULT_CYC(FC), .QUAL_CYC(QC), .EXT65_CYC(E65),
    .EXT100_CYC(E100), .LHI_CYC(LH), .LLO_CYC(LL), .OFF_CYC(OFF),
    .SS_CYC(SS), .AUTOREC_CYC(AR)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .current_limit_level,
    .cs_stop_level, .vcc_below_off, .vcc_below_reset, .vcc_above_on,
    .vcc_above_ovp, .ext_latch_req, .latch_pin_high, .latch_pin_low,
    .thermal_shutdown_flag, .thermal_fault_cleared,
    .offmode_feedback_threshold, .onmode_feedback_threshold,
    .x2_discharge_done, .gate_drive_output, .softstart_bias_boost,
    .hv_startup_enable, .internal_supply_enable);
  initial begin
    forever #4 aclk = ~aclk;
  end
  task tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : tick
  task set(input int b, input logic v);
    @(posedge aclk);
    flt[b] <= v;
  endtask : set
  task vc(input logic [2:0] v);
    @(posedge aclk);
    vcc_code <= v;
  endtask : vc
  task chk(input logic [31:0] s, input logic [31:0] e, input string m);
    compares++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  // status word: outputs {gate,boost,hv,supply}, causes, state
  function logic [31:0] stv(input logic [2:0] s, input logic [5:0] c,
                            input logic [3:0] o);
    return {16'h0, o, 2'h0, c, 1'h0, s};
  endfunction : stv
  task cks(input logic [31:0] e, input string m);
    #1;
    chk({gate_drive_output, softstart_bias_boost, hv_startup_enable,
         internal_supply_enable}, e[15:12], m);
    rd(4'h4);
    chk(d, e, m);
  endtask : cks
  task up;
    tick(SS + 6);
    cks(stv(3'h2, 6'h0, 4'hB), "not running");
  endtask : up
  task tdone(input string m);
    $display("test %s done", m);
  endtask : tdone
  task close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    tick(1);
    cks(stv(3'h0, 6'h0, 4'h3), "reset status");
    rd(4'h0);
    chk(d, 32'h0, "ctrl reset");
    rd(4'h8);
    chk(r, 2'h2, "unmapped read");
    wr(4'h8, 32'h1);
    chk(r, 2'h2, "unmapped write");
    wr(4'h4, 32'hFFFFFFFF);
    chk(r, 2'h0, "status write okay");
    tdone("reset");
    vc(3'h3);
    set(4, 1'h1);
    tick(2);
    cks(stv(3'h1, 6'h0, 4'hF), "soft-start boost");
    tick(SS - 6);
    set(4, 1'h0);
    up();
    tdone("startup");
    set(0, 1'h1);
    tick(FC - 2);
    set(0, 1'h0);
    set(0, 1'h1);
    tick(FC - 2);
    chk(gate_drive_output, 1'h1, "timer not cleared");
    tick(6);
    set(0, 1'h0);
    cks(stv(3'h3, 6'h01, 4'h3), "oc latch");
    tick(FC);
    chk(gate_drive_output, 1'h0, "gate while latched");
    set(6, 1'h1);
    set(6, 1'h0);
    tick(3);
    cks(stv(3'h1, 6'h0, 4'hF), "x2 release");
    up();
    set(1, 1'h1);
    set(1, 1'h0);
    tick(2);
    cks(stv(3'h3, 6'h02, 4'h3), "short latch");
    vc(3'h0);
    tick(3);
    cks(stv(3'h0, 6'h0, 4'h3), "short release");
    vc(3'h3);
    up();
    tdone("overcurrent");
    vc(3'h4);
    tick(QC + 4);
    cks(stv(3'h3, 6'h10, 4'h3), "ovp latch");
    vc(3'h3);
    tick(3);
    chk(gate_drive_output, 1'h0, "ovp early release");
    vc(3'h0);
    vc(3'h3);
    up();
    vc(3'h1);
    tick(QC + 4);
    chk(gate_drive_output, 1'h0, "low supply");
    vc(3'h0);
    vc(3'h3);
    up();
    tdone("supply");
    set(3, 1'h1);
    tick(LH - 2);
    set(3, 1'h0);
    tick(2);
    chk(gate_drive_output, 1'h1, "spike latched");
    set(3, 1'h1);
    tick(LH + 4);
    cks(stv(3'h3, 6'h20, 4'h3), "pin high latch");
    set(6, 1'h1);
    set(6, 1'h0);
    tick(3);
    cks(stv(3'h3, 6'h20, 4'h3), "x2 freed pin");
    vc(3'h0);
    tick(3);
    cks(stv(3'h0, 6'h0, 4'h3), "pin reset");
    vc(3'h3);
    tick(3);
    cks(stv(3'h3, 6'h20, 4'h3), "turn-on check");
    set(3, 1'h0);
    vc(3'h0);
    vc(3'h3);
    up();
    set(4, 1'h1);
    tick(LL + 4);
    set(4, 1'h0);
    cks(stv(3'h3, 6'h20, 4'h3), "pin low latch");
    vc(3'h0);
    vc(3'h3);
    up();
    tdone("latch pin");
    wr(4'h0, 32'h1);
    rd(4'h0);
    chk(d, 32'h1, "ctrl readback");
    set(0, 1'h1);
    tick(FC + 4);
    chk(gate_drive_output, 1'h0, "autorec latch");
    set(0, 1'h0);
    tick(AR + 4);
    cks(stv(3'h1, 6'h0, 4'hF), "autorec restart");
    up();
    wr(4'h0, 32'h2);
    set(2, 1'h1);
    tick(E100 + 4);
    cks(stv(3'h3, 6'h08, 4'h3), "ext 100k latch");
    set(2, 1'h0);
    vc(3'h2);
    tick(2);
    cks(stv(3'h0, 6'h0, 4'h3), "ext release");
    vc(3'h3);
    up();
    wr(4'h0, 32'h0);
    set(2, 1'h1);
    tick(E100 + 4);
    chk(gate_drive_output, 1'h1, "ext 65k early");
    tick(E65);
    chk(gate_drive_output, 1'h0, "ext 65k latch");
    set(2, 1'h0);
    vc(3'h2);
    vc(3'h3);
    up();
    tdone("options");
    set(7, 1'h1);
    tick(2);
    chk(gate_drive_output, 1'h0, "thermal gate");
    tick(QC + 4);
    cks(stv(3'h5, 6'h0, 4'h1), "thermal stop");
    set(7, 1'h0);
    tick(3);
    cks(stv(3'h1, 6'h0, 4'hF), "thermal restart");
    up();
    set(5, 1'h1);
    set(8, 1'h0);
    tick(OFF + 4);
    set(5, 1'h0);
    tick(3);
    cks(stv(3'h6, 6'h0, 4'h2), "off mode");
    set(8, 1'h1);
    tick(3);
    cks(stv(3'h1, 6'h0, 4'hF), "off mode restart");
    tdone("stop modes");
    close_out;
  end
endmodule : flyback_protection_latch_sequencer_test
`default_nettype wire
